// *** sbc_defines.vh ***
`ifndef SBC_DEFINES_VH
`define SBC_DEFINES_VH

// ----------------------------------------------------------------
// Parser states
// ----------------------------------------------------------------
`define SBC_ST_IDLE 2'h0
`define SBC_ST_NUM 2'h1
`define SBC_ST_TERM 2'h2

// ----------------------------------------------------------------
// Command letters and special characters
// ----------------------------------------------------------------
`define SBC_CH_MASK 8'h4D
`define SBC_CH_TRIG 8'h54
`define SBC_CH_POLE 8'h41
`define SBC_CH_DISP 8'h42
`define SBC_CH_CLOSE 8'h43
`define SBC_CH_TERM 8'h59
`define SBC_CH_EXEC 8'h58
`define SBC_CH_LF 8'h0A
`define SBC_CH_CR 8'h0D
`define SBC_CH_DEL 8'h7F
`define SBC_CH_SPACE 8'h20
`define SBC_CH_PLUS 8'h2B
`define SBC_CH_COMMA 8'h2C
`define SBC_CH_MINUS 8'h2D
`define SBC_CH_PERIOD 8'h2E
`define SBC_CH_SLASH 8'h2F
`define SBC_CH_COLON 8'h3A
`define SBC_CH_LOW_E 8'h65
`define SBC_CH_DIG0 8'h30
`define SBC_CH_DIG9 8'h39
`define SBC_CH_CAP_A 8'h41
`define SBC_CH_CAP_Z 8'h5A

// ----------------------------------------------------------------
// Terminator modes
// ----------------------------------------------------------------
`define SBC_TM_CRLF 2'h0
`define SBC_TM_LFCR 2'h1
`define SBC_TM_NONE 2'h2
`define SBC_TM_CHAR 2'h3

// ----------------------------------------------------------------
// Pole configurations
// ----------------------------------------------------------------
`define SBC_PM_MATRIX 2'h0
`define SBC_PM_1POLE 2'h1
`define SBC_PM_2POLE 2'h2
`define SBC_PM_4POLE 2'h3

// ----------------------------------------------------------------
// Trigger modes
// ----------------------------------------------------------------
`define SBC_T_TALK_START 3'h0
`define SBC_T_TALK_STOP 3'h1
`define SBC_T_GET_START 3'h2
`define SBC_T_GET_STOP 3'h3
`define SBC_T_X_START 3'h4
`define SBC_T_X_STOP 3'h5
`define SBC_T_EXT_START 3'h6
`define SBC_T_EXT_STOP 3'h7

// ----------------------------------------------------------------
// Limits and reset values
// ----------------------------------------------------------------
`define SBC_MASK_MAX 10'h03F
`define SBC_TRIG_MAX 10'h007
`define SBC_POLE_MAX 10'h004
`define SBC_NUM_SAT 10'h3FF
`define SBC_NUM_DIGITS 3'h3
`define SBC_ROW_MAX 4'h4
`define SBC_UNITS_MAX 3'h5
`define SBC_COLS_PER_UNIT 10'h00A
`define SBC_RST_MASK 6'h00
`define SBC_RST_TRIG 3'h0
`define SBC_RST_POLE 2'h1
`define SBC_RST_DISP 10'h001

`endif

// *** sbc_scanner_bus_cmd.v ***
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defines.vh"

// Functional notes
// - Power-up: mask zero, no service requests
// - Serial poll read clears status byte
// - Mask letter plus decimal 0..63 loads mask
// - Mask bits select which events raise request
// - Any mask combination; any enabled event requests
// - Trigger 0 start, 1 stop on talk
// - Trigger 2 start, 3 stop on GET
// - Trigger 4 start, 5 stop on execute
// - Trigger 6 start, 7 stop on external
// - Talk then data request: no start; stop if scan active
// - Terminator CR LF at power-up and clear
// - Terminator letter plus one legal character
// - LF, CR, DEL select special terminators
// - Pole argument 0..4 selects configuration
// - Matrix channel: column digits then row
// - Channel count from poles and units
// - Display beyond last: option error, keep
// - Close letter plus channel closes relay
module sbc_scanner_bus_cmd #(
  parameter CH_PER_UNIT_1POLE = 10'd40,
  parameter CH_PER_UNIT_2POLE = 10'd20,
  parameter CH_PER_UNIT_4POLE = 10'd10
) (
  input wire sys_clk,
  input wire arst_n,
  input wire rx_valid,
  input wire [7:0] rx_byte,
  input wire talk_addr,
  input wire talk_release,
  input wire data_req,
  input wire get_cmd,
  input wire dev_clear,
  input wire spoll_rd,
  input wire ext_trig,
  input wire [2:0] chain_units,
  input wire scan_active,
  input wire ev_settle_end,
  input wire ev_interval_end,
  input wire ev_scan_end,
  input wire ev_timer_alarm,
  input wire ev_serial_loop,
  input wire ev_not_remote,
  output reg [7:0] service_request_mask_r,
  output reg [7:0] serial_poll_status_byte_r,
  output reg srq_r,
  output reg [2:0] trig_mode_r,
  output reg scan_start_r,
  output reg scan_stop_r,
  output reg [1:0] term_mode_r,
  output reg [7:0] term_char_r,
  output reg [1:0] pole_mode_r,
  output reg [9:0] disp_channel_r,
  output reg [9:0] close_channel_r,
  output reg close_strobe_r,
  output reg illegal_command_error_r,
  output reg illegal_option_error_r
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg ext_meta_r;
  reg ext_sync_r;
  reg ext_prev_r;
  reg [2:0] units_meta_r;
  reg [2:0] units_sync_r;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
      ext_prev_r <= 1'b0;
      units_meta_r <= 3'h1;
      units_sync_r <= 3'h1;
    end else begin
      ext_meta_r <= ext_trig;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
      units_meta_r <= chain_units;
      units_sync_r <= units_meta_r;
    end
  end

  wire ext_rise = ext_sync_r & ~ext_prev_r;

  // ----------------------------------------------------------------
  // Channel limits
  // ----------------------------------------------------------------
  reg [2:0] units;
  reg [9:0] last_channel;
  reg [9:0] per_unit;

  always @* begin
    units = units_sync_r;
    if (units == 3'h0)
      units = 3'h1;
    if (units > `SBC_UNITS_MAX)
      units = `SBC_UNITS_MAX;
    case (pole_mode_r)
      `SBC_PM_1POLE: per_unit = CH_PER_UNIT_1POLE;
      `SBC_PM_2POLE: per_unit = CH_PER_UNIT_2POLE;
      `SBC_PM_4POLE: per_unit = CH_PER_UNIT_4POLE;
      default: per_unit = `SBC_COLS_PER_UNIT;
    endcase
    last_channel = per_unit * {7'h00, units};
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [1:0] st_r;
  reg [7:0] cmd_r;
  reg [9:0] num_r;
  reg [2:0] ndig_r;
  reg talk_pend_r;
  reg [3:0] data_pend_r;
  reg [3:0] err_pend_r;

  reg [1:0] st_nxt;
  reg [7:0] cmd_nxt;
  reg [9:0] num_nxt;
  reg [2:0] ndig_nxt;
  reg talk_pend_nxt;
  reg [3:0] data_pend_nxt;
  reg [3:0] err_pend_nxt;
  reg [5:0] mask_nxt;
  reg [7:0] stb_nxt;
  reg [2:0] trig_nxt;
  reg start_nxt;
  reg stop_nxt;
  reg [1:0] term_mode_nxt;
  reg [7:0] term_char_nxt;
  reg [1:0] pole_nxt;
  reg [9:0] disp_nxt;
  reg [9:0] close_ch_nxt;
  reg close_nxt;
  reg ill_cmd_nxt;
  reg ill_opt_nxt;
  reg exec;
  reg new_cmd;
  reg x_seen;
  reg is_digit;
  reg bad_term;
  reg chan_ok;
  reg [9:0] col;
  reg [9:0] rem;
  reg [3:0] row;

  // ----------------------------------------------------------------
  // Command parser and executor
  // ----------------------------------------------------------------
  always @* begin
    st_nxt = st_r;
    cmd_nxt = cmd_r;
    num_nxt = num_r;
    ndig_nxt = ndig_r;
    mask_nxt = service_request_mask_r[5:0];
    trig_nxt = trig_mode_r;
    term_mode_nxt = term_mode_r;
    term_char_nxt = term_char_r;
    pole_nxt = pole_mode_r;
    disp_nxt = disp_channel_r;
    close_ch_nxt = close_channel_r;
    close_nxt = 1'b0;
    ill_cmd_nxt = 1'b0;
    ill_opt_nxt = 1'b0;
    exec = 1'b0;
    new_cmd = 1'b0;
    x_seen = 1'b0;
    is_digit = (rx_byte >= `SBC_CH_DIG0) && (rx_byte <= `SBC_CH_DIG9);
    bad_term = ((rx_byte >= `SBC_CH_CAP_A) && (rx_byte <= `SBC_CH_CAP_Z)) || is_digit ||
               (rx_byte == `SBC_CH_SPACE) || (rx_byte == `SBC_CH_PLUS) ||
               (rx_byte == `SBC_CH_MINUS) || (rx_byte == `SBC_CH_SLASH) ||
               (rx_byte == `SBC_CH_COMMA) || (rx_byte == `SBC_CH_PERIOD) ||
               (rx_byte == `SBC_CH_LOW_E) || (rx_byte == `SBC_CH_COLON);
    // Matrix channel splits into column (upper digits) and row (last digit)
    col = num_r / 10'd10;
    rem = num_r - col * 10'd10;
    row = rem[3:0];
    if (pole_mode_r == `SBC_PM_MATRIX)
      chan_ok = (row >= 4'h1) && (row <= `SBC_ROW_MAX) && (col >= 10'h001) &&
                (col <= last_channel);
    else
      chan_ok = (num_r >= 10'h001) && (num_r <= last_channel);

    case (st_r)
      `SBC_ST_IDLE: begin
        if (rx_valid)
          new_cmd = 1'b1;
      end
      `SBC_ST_NUM: begin
        if (rx_valid) begin
          if (is_digit) begin
            ndig_nxt = (ndig_r == 3'h7) ? ndig_r : ndig_r + 3'h1;
            if (num_r > 10'd101)
              num_nxt = `SBC_NUM_SAT;
            else
              num_nxt = (num_r * 10'd10) + {2'h0, rx_byte - `SBC_CH_DIG0};
          end else begin
            exec = 1'b1;
            new_cmd = 1'b1;
          end
        end
      end
      `SBC_ST_TERM: begin
        if (rx_valid) begin
          st_nxt = `SBC_ST_IDLE;
          if (rx_byte == `SBC_CH_LF) begin
            term_mode_nxt = `SBC_TM_CRLF;
          end else if (rx_byte == `SBC_CH_CR) begin
            term_mode_nxt = `SBC_TM_LFCR;
          end else if (rx_byte == `SBC_CH_DEL) begin
            term_mode_nxt = `SBC_TM_NONE;
          end else if (bad_term) begin
            ill_opt_nxt = 1'b1;
          end else begin
            term_mode_nxt = `SBC_TM_CHAR;
            term_char_nxt = rx_byte;
          end
        end
      end
      default: st_nxt = `SBC_ST_IDLE;
    endcase

    if (exec) begin
      if (ndig_r > `SBC_NUM_DIGITS) begin
        ill_opt_nxt = 1'b1;
      end else begin
        case (cmd_r)
          `SBC_CH_MASK: begin
            if (num_r > `SBC_MASK_MAX)
              ill_opt_nxt = 1'b1;
            else
              mask_nxt = num_r[5:0];
          end
          `SBC_CH_TRIG: begin
            if (num_r > `SBC_TRIG_MAX)
              ill_opt_nxt = 1'b1;
            else
              trig_nxt = num_r[2:0];
          end
          `SBC_CH_POLE: begin
            if (num_r > `SBC_POLE_MAX)
              ill_opt_nxt = 1'b1;
            else if (num_r == 10'h004)
              pole_nxt = `SBC_PM_4POLE;
            else
              pole_nxt = num_r[1:0];
          end
          `SBC_CH_DISP: begin
            if (chan_ok)
              disp_nxt = num_r;
            else
              ill_opt_nxt = 1'b1;
          end
          `SBC_CH_CLOSE: begin
            if (chan_ok) begin
              close_ch_nxt = num_r;
              close_nxt = 1'b1;
            end else begin
              ill_opt_nxt = 1'b1;
            end
          end
          default: ill_cmd_nxt = 1'b1;
        endcase
      end
    end

    if (new_cmd) begin
      st_nxt = `SBC_ST_IDLE;
      num_nxt = 10'h000;
      ndig_nxt = 3'h0;
      case (rx_byte)
        `SBC_CH_MASK, `SBC_CH_TRIG, `SBC_CH_POLE, `SBC_CH_DISP, `SBC_CH_CLOSE: begin
          st_nxt = `SBC_ST_NUM;
          cmd_nxt = rx_byte;
        end
        `SBC_CH_TERM: st_nxt = `SBC_ST_TERM;
        `SBC_CH_EXEC: x_seen = 1'b1;
        `SBC_CH_SPACE, `SBC_CH_COMMA, `SBC_CH_CR, `SBC_CH_LF: st_nxt = `SBC_ST_IDLE;
        default: begin
          // Other command letters belong to neighbouring handlers
          if (!((rx_byte >= `SBC_CH_CAP_A) && (rx_byte <= `SBC_CH_CAP_Z)))
            ill_cmd_nxt = 1'b1;
        end
      endcase
    end

    if (dev_clear) begin
      term_mode_nxt = `SBC_TM_CRLF;
      st_nxt = `SBC_ST_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Trigger handling
  // ----------------------------------------------------------------
  always @* begin
    start_nxt = 1'b0;
    stop_nxt = 1'b0;
    talk_pend_nxt = talk_pend_r;
    case (trig_mode_r)
      `SBC_T_TALK_START: begin
        if (data_req) begin
          talk_pend_nxt = 1'b0;
          stop_nxt = scan_active;
        end else if (talk_release && talk_pend_r) begin
          talk_pend_nxt = 1'b0;
          start_nxt = 1'b1;
        end else if (talk_addr) begin
          talk_pend_nxt = 1'b1;
        end
      end
      `SBC_T_TALK_STOP: begin
        talk_pend_nxt = 1'b0;
        stop_nxt = talk_addr;
      end
      `SBC_T_GET_START: start_nxt = get_cmd;
      `SBC_T_GET_STOP: stop_nxt = get_cmd;
      `SBC_T_X_START: start_nxt = x_seen;
      `SBC_T_X_STOP: stop_nxt = x_seen;
      `SBC_T_EXT_START: start_nxt = ext_rise;
      `SBC_T_EXT_STOP: stop_nxt = ext_rise;
      default: talk_pend_nxt = 1'b0;
    endcase
    if (trig_mode_r != `SBC_T_TALK_START)
      talk_pend_nxt = 1'b0;
  end

  // ----------------------------------------------------------------
  // Service request status
  // ----------------------------------------------------------------
  always @* begin
    data_pend_nxt = spoll_rd ? 4'h0 : data_pend_r;
    err_pend_nxt = spoll_rd ? 4'h0 : err_pend_r;
    // New events win over the poll clear
    if (mask_nxt[4] && ev_settle_end)
      data_pend_nxt[3] = 1'b1;
    if (mask_nxt[3] && ev_interval_end)
      data_pend_nxt[2] = 1'b1;
    if (mask_nxt[2] && ev_scan_end)
      data_pend_nxt[1] = 1'b1;
    if (mask_nxt[1] && ev_timer_alarm)
      data_pend_nxt[0] = 1'b1;
    if (mask_nxt[5] && ev_serial_loop)
      err_pend_nxt[3] = 1'b1;
    if (mask_nxt[0] && ev_not_remote)
      err_pend_nxt[2] = 1'b1;
    if (mask_nxt[0] && ill_opt_nxt)
      err_pend_nxt[1] = 1'b1;
    if (mask_nxt[0] && ill_cmd_nxt)
      err_pend_nxt[0] = 1'b1;
    // Error form takes priority over data form
    if (err_pend_nxt != 4'h0)
      stb_nxt = {1'b0, 1'b1, 1'b1, 1'b0, err_pend_nxt};
    else if (data_pend_nxt != 4'h0)
      stb_nxt = {1'b0, 1'b1, 1'b0, data_pend_nxt, 1'b0};
    else
      stb_nxt = 8'h00;
  end

  // ----------------------------------------------------------------
  // State update
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= `SBC_ST_IDLE;
      cmd_r <= 8'h00;
      num_r <= 10'h000;
      ndig_r <= 3'h0;
      talk_pend_r <= 1'b0;
      data_pend_r <= 4'h0;
      err_pend_r <= 4'h0;
      service_request_mask_r <= {2'h0, `SBC_RST_MASK};
      serial_poll_status_byte_r <= 8'h00;
      srq_r <= 1'b0;
      trig_mode_r <= `SBC_RST_TRIG;
      scan_start_r <= 1'b0;
      scan_stop_r <= 1'b0;
      term_mode_r <= `SBC_TM_CRLF;
      term_char_r <= 8'h00;
      pole_mode_r <= `SBC_RST_POLE;
      disp_channel_r <= `SBC_RST_DISP;
      close_channel_r <= 10'h000;
      close_strobe_r <= 1'b0;
      illegal_command_error_r <= 1'b0;
      illegal_option_error_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cmd_r <= cmd_nxt;
      num_r <= num_nxt;
      ndig_r <= ndig_nxt;
      talk_pend_r <= talk_pend_nxt;
      data_pend_r <= data_pend_nxt;
      err_pend_r <= err_pend_nxt;
      service_request_mask_r <= {2'h0, mask_nxt};
      serial_poll_status_byte_r <= stb_nxt;
      srq_r <= stb_nxt[6];
      trig_mode_r <= trig_nxt;
      scan_start_r <= start_nxt;
      scan_stop_r <= stop_nxt;
      term_mode_r <= term_mode_nxt;
      term_char_r <= term_char_nxt;
      pole_mode_r <= pole_nxt;
      disp_channel_r <= disp_nxt;
      close_channel_r <= close_ch_nxt;
      close_strobe_r <= close_nxt;
      illegal_command_error_r <= ill_cmd_nxt;
      illegal_option_error_r <= ill_opt_nxt;
    end
  end

endmodule // sbc_scanner_bus_cmd

`default_nettype wire

// *** sbc_scanner_bus_cmd_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defines.vh"
module sbc_scanner_bus_cmd_chk (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic talk_addr,
  input wire logic get_cmd,
  input wire logic spoll_rd,
  input wire logic ext_trig,
  input wire logic ev_settle_end,
  input wire logic ev_interval_end,
  input wire logic ev_scan_end,
  input wire logic ev_timer_alarm,
  input wire logic ev_serial_loop,
  input wire logic ev_not_remote,
  input wire logic [7:0] service_request_mask_r,
  input wire logic [7:0] serial_poll_status_byte_r,
  input wire logic srq_r,
  input wire logic [2:0] trig_mode_r,
  input wire logic scan_start_r,
  input wire logic scan_stop_r,
  input wire logic illegal_command_error_r,
  input wire logic illegal_option_error_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire logic any_ev;
  wire logic [7:0] msk;
  wire logic [7:0] stb;
  assign any_ev = ev_settle_end | ev_interval_end | ev_scan_end | ev_timer_alarm |
                  ev_serial_loop | ev_not_remote;
  assign msk = service_request_mask_r;
  assign stb = serial_poll_status_byte_r;
  // ----------------------------------------------------------------
  // Service request
  // ----------------------------------------------------------------
  property p_rst_clean;
    !$past(arst_n) |-> msk == 8'h00 && stb == 8'h00 && !srq_r;
  endproperty
  a_rst_clean: assert property (p_rst_clean) else $error("state not clean after reset");
  property p_srq_bit;
    srq_r == stb[6];
  endproperty
  a_srq_bit: assert property (p_srq_bit) else $error("srq differs from status bit 6");
  property p_mask_top;
    msk[7:6] == 2'b00;
  endproperty
  a_mask_top: assert property (p_mask_top) else $error("mask upper bits set");
  property p_spoll_clr;
    spoll_rd && !any_ev |=> stb == 8'h00 || illegal_command_error_r || illegal_option_error_r;
  endproperty
  a_spoll_clr: assert property (p_spoll_clr) else $error("status kept after poll");
  property p_scan_req;
    ev_scan_end && msk[2] |=> srq_r;
  endproperty
  a_scan_req: assert property (p_scan_req) else $error("enabled scan end gave no request");
  property p_loop_err;
    ev_serial_loop && msk[5] |=> stb[6:5] == 2'b11 && stb[3];
  endproperty
  a_loop_err: assert property (p_loop_err) else $error("loop event not in error form");
  property p_unmasked;
    stb == 8'h00 && msk == 8'h00 ##1 msk == 8'h00 ##1 msk == 8'h00 |-> stb == 8'h00;
  endproperty
  a_unmasked: assert property (p_unmasked) else $error("request with empty mask");
  // ----------------------------------------------------------------
  // Triggers
  // ----------------------------------------------------------------
  property p_get_start;
    get_cmd && trig_mode_r == `SBC_T_GET_START |=> scan_start_r;
  endproperty
  a_get_start: assert property (p_get_start) else $error("GET did not start");
  property p_get_stop;
    get_cmd && trig_mode_r == `SBC_T_GET_STOP |=> scan_stop_r && !scan_start_r;
  endproperty
  a_get_stop: assert property (p_get_stop) else $error("GET did not stop");
  property p_talk_stop;
    talk_addr && trig_mode_r == `SBC_T_TALK_STOP |=> scan_stop_r;
  endproperty
  a_talk_stop: assert property (p_talk_stop) else $error("talk did not stop");
  property p_ext_start;
    $rose(ext_trig) && trig_mode_r == `SBC_T_EXT_START |-> ##[1:4] scan_start_r;
  endproperty
  a_ext_start: assert property (p_ext_start) else $error("external edge did not start");
  c_start: cover property (scan_start_r);
  c_stop: cover property (scan_stop_r);
  c_poll: cover property (spoll_rd && srq_r);
endmodule // sbc_scanner_bus_cmd_chk
`default_nettype wire

// *** sbc_ctl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbc_ctl_model (
  input wire logic sys_clk,
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end
  // Bytes back to back, line scrambled when idle
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_byte <= s[i];
    end
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_byte <= ~rx_byte;
  endtask
endmodule // sbc_ctl_model
`default_nettype wire

// *** sbc_scanner_bus_cmd_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defines.vh"
module sbc_scanner_bus_cmd_tb_top;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] pv = 12'h000;
  logic ext_trig = 1'b0;
  logic scan_active = 1'b0;
  logic [2:0] chain_units = 3'h1;
  wire logic rx_valid, srq, start, stop, cls, icmd, iopt;
  wire logic [7:0] rx_byte, mask, stat, term_char;
  wire logic [2:0] trig;
  wire logic [1:0] term_mode, pole;
  wire logic [9:0] disp, close_ch;
  int fail_count = 0, num_checks = 0, cyc = 0, n_start = 0, n_stop = 0, n_opt = 0;
  int s0, p0, o;
  int n_cmd = 0;
  logic [9:0] last_close = 10'h000;
  logic [31:0] rs = 32'hFDA3;
  string bad = "A5 +-/,.e:";
  logic [7:0] tc [4] = '{8'h0A, 8'h0D, 8'h7F, 8'h74};
  always #25 sys_clk = ~sys_clk;
  sbc_ctl_model i_sbc_ctl_model (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_byte(rx_byte));
  sbc_scanner_bus_cmd i_sbc_scanner_bus_cmd (.sys_clk(sys_clk), .arst_n(arst_n),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .talk_addr(pv[0]), .talk_release(pv[1]),
    .data_req(pv[2]), .get_cmd(pv[3]), .dev_clear(pv[4]), .spoll_rd(pv[5]),
    .ext_trig(ext_trig), .chain_units(chain_units), .scan_active(scan_active),
    .ev_settle_end(pv[6]), .ev_interval_end(pv[7]), .ev_scan_end(pv[8]),
    .ev_timer_alarm(pv[9]), .ev_serial_loop(pv[10]), .ev_not_remote(pv[11]),
    .service_request_mask_r(mask), .serial_poll_status_byte_r(stat), .srq_r(srq),
    .trig_mode_r(trig), .scan_start_r(start), .scan_stop_r(stop), .term_mode_r(term_mode),
    .term_char_r(term_char), .pole_mode_r(pole), .disp_channel_r(disp),
    .close_channel_r(close_ch), .close_strobe_r(cls), .illegal_command_error_r(icmd),
    .illegal_option_error_r(iopt));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [7:0] ev_exp(input int i);
    logic [7:0] t [6] = '{8'h50, 8'h48, 8'h44, 8'h42, 8'h68, 8'h64};
    return t[i];
  endfunction
  function automatic int mbit(input int i);
    int t [6] = '{4, 3, 2, 1, 5, 0};
    return t[i];
  endfunction
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic pulse(input int k);
    @(posedge sys_clk);
    pv[k] <= 1'b1;
    @(posedge sys_clk);
    pv[k] <= 1'b0;
    waitc(2);
  endtask
  task automatic cmd(input string s);
    i_sbc_ctl_model.send(s);
    waitc(3);
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (start === 1'b1) n_start <= n_start + 1;
    if (stop === 1'b1) n_stop <= n_stop + 1;
    if (iopt === 1'b1) n_opt <= n_opt + 1;
    if (icmd === 1'b1) n_cmd <= n_cmd + 1;
    if (cls === 1'b1) last_close <= close_ch;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    waitc(3);
    chk("mask", 8'h00, mask);
    chk("status", 8'h00, stat);
    chk("term", `SBC_TM_CRLF, term_mode);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      rs = lfsr(rs);
      cmd($sformatf("M%0dX", rs[5:0]));
      chk("mask", rs[5:0], mask);
    end
    cmd("M1X");
    o = n_opt;
    cmd("M64X");
    chk("mask", 8'h01, mask);
    chk("opt count", o + 1, n_opt);
    chk("opt status", 8'h62, stat);
    pulse(5);
    o = n_cmd;
    cmd("#");
    chk("cmd status", 8'h61, stat);
    chk("cmd count", o + 1, n_cmd);
    pulse(5);
    for (int i = 0; i < 6; i++) begin
      cmd($sformatf("M%0dX", 1 << mbit(i)));
      pulse(6 + (i + 1) % 6);
      chk("masked", 8'h00, stat);
      pulse(6 + i);
      chk("single", ev_exp(i), stat);
      pulse(5);
    end
    cmd("M63X");
    for (int i = 0; i < 6; i++) begin
      pulse(6 + i);
      chk("status", ev_exp(i), stat);
      chk("srq", 1'b1, srq);
      pulse(5);
      chk("cleared", 8'h00, stat);
    end
    cmd("M0X");
    $display("test service request done");
    for (int m = 0; m < 8; m++) begin
      cmd($sformatf("T%0dX", m));
      chk("trig", m, trig);
      if (m == 0) begin
        s0 = n_start;
        pulse(0);
        pulse(2);
        pulse(1);
        chk("talk then data", s0, n_start);
      end
      s0 = n_start;
      p0 = n_stop;
      case (m / 2)
        0: begin
          pulse(0);
          if (m == 0) pulse(1);
        end
        1: pulse(3);
        2: cmd("X");
        default: begin
          @(posedge sys_clk);
          ext_trig <= 1'b1;
          waitc(6);
          ext_trig <= 1'b0;
        end
      endcase
      waitc(3);
      chk("starts", s0 + (m % 2 == 0), n_start);
      chk("stops", p0 + (m % 2 == 1), n_stop);
      if (m == 0) begin
        scan_active <= 1'b1;
        pulse(2);
        scan_active <= 1'b0;
        chk("data stops", p0 + 1, n_stop);
      end
    end
    o = n_opt;
    cmd("T8X");
    chk("trig kept", 3'h7, trig);
    chk("opt count", o + 1, n_opt);
    $display("test trigger done");
    for (int i = 0; i < 4; i++) begin
      cmd($sformatf("Y%c", tc[i]));
      chk("term mode", i, term_mode);
    end
    chk("term char", 8'h74, term_char);
    o = n_opt;
    for (int i = 0; i < bad.len(); i++) begin
      cmd($sformatf("Y%cX", bad[i]));
      chk("term kept", `SBC_TM_CHAR, term_mode);
      chk("char kept", 8'h74, term_char);
    end
    chk("opt count", o + bad.len(), n_opt);
    pulse(4);
    chk("term clear", `SBC_TM_CRLF, term_mode);
    $display("test terminator done");
    for (int a = 0; a < 5; a++) begin
      cmd($sformatf("A%0dX", a));
      chk("pole", (a > 3) ? 3 : a, pole);
    end
    cmd("A1X");
    rs = lfsr(rs);
    s0 = rs % 40 + 1;
    cmd($sformatf("B%0dX", s0));
    chk("disp", s0, disp);
    o = n_opt;
    cmd("B41X");
    chk("disp kept", s0, disp);
    chk("opt count", o + 1, n_opt);
    chain_units <= 3'h2;
    waitc(4);
    cmd("B80X");
    chk("disp two units", 80, disp);
    cmd("A2X");
    cmd("B41X");
    chk("disp 2-pole", 80, disp);
    cmd("C7X");
    chk("close", 7, last_close);
    cmd("A0X");
    cmd("C042X");
    chk("close matrix", 42, last_close);
    cmd("C204X");
    chk("close col 20", 204, last_close);
    o = n_opt;
    cmd("C045X");
    chk("bad row", 204, last_close);
    chk("opt count", o + 1, n_opt);
    $display("test channels done");
    end_sim();
  end
endmodule // sbc_scanner_bus_cmd_tb_top
bind sbc_scanner_bus_cmd sbc_scanner_bus_cmd_chk i_sbc_scanner_bus_cmd_chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .talk_addr(talk_addr), .get_cmd(get_cmd),
  .spoll_rd(spoll_rd), .ext_trig(ext_trig), .ev_settle_end(ev_settle_end),
  .ev_interval_end(ev_interval_end), .ev_scan_end(ev_scan_end),
  .ev_timer_alarm(ev_timer_alarm), .ev_serial_loop(ev_serial_loop),
  .ev_not_remote(ev_not_remote), .service_request_mask_r(service_request_mask_r),
  .serial_poll_status_byte_r(serial_poll_status_byte_r), .srq_r(srq_r),
  .trig_mode_r(trig_mode_r), .scan_start_r(scan_start_r), .scan_stop_r(scan_stop_r),
  .illegal_command_error_r(illegal_command_error_r),
  .illegal_option_error_r(illegal_option_error_r));
`default_nettype wire
